/* File: design/fer_axil.sv */
`timescale 1ns/10ps
`default_nettype none
module fer_axil (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [fer_pkg::ADDR_W-1:0] awaddr_in,
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [fer_pkg::ADDR_W-1:0] araddr_in,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic wr_en_out,
  output logic [fer_pkg::ADDR_W-1:0] wr_addr_out,
  output logic [31:0] wr_data_out,
  output logic [3:0] wr_strb_out,
  input wire logic wr_ok_in,
  output logic [fer_pkg::ADDR_W-1:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_ok_in
);
  import fer_pkg::*;
  logic aw_held_r;
  logic w_held_r;
  logic aw_held_nxt;
  logic w_held_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;

  // readies are registered from next state so a taken item closes its channel at once
  always_comb begin
    aw_held_nxt = aw_held_r | (awvalid_in & awready_out);
    w_held_nxt = w_held_r | (wvalid_in & wready_out);
    bvalid_nxt = bvalid_out & ~bready_in;
    if (wr_en_out) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
    end
    rvalid_nxt = rvalid_out & ~rready_in;
    if (arvalid_in && arready_out) begin
      rvalid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      arready_out <= 1'b0;
    end else begin
      awready_out <= !aw_held_nxt && !bvalid_nxt;
      wready_out <= !w_held_nxt && !bvalid_nxt;
      arready_out <= !rvalid_nxt;
    end
  end

  // address and data may arrive in either order; each is held once taken
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_en_out <= 1'b0;
      wr_addr_out <= '0;
      wr_data_out <= '0;
      wr_strb_out <= '0;
      bvalid_out <= 1'b0;
      bresp_out <= RESP_OKAY;
    end else begin
      wr_en_out <= 1'b0;
      if (awvalid_in && awready_out) begin
        aw_held_r <= 1'b1;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_held_r <= 1'b1;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (aw_held_r && w_held_r && !bvalid_out && !wr_en_out) begin
        wr_en_out <= 1'b1;
      end
      if (wr_en_out) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out <= wr_ok_in ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  assign rd_addr_out = araddr_in;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rvalid_out <= 1'b0;
      rdata_out <= '0;
      rresp_out <= RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      rvalid_out <= 1'b1;
      rdata_out <= rd_data_in;
      rresp_out <= rd_ok_in ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
    end
  end
endmodule : fer_axil
`default_nettype wire

/* File: design/fer_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module fer_decode (
  input wire fer_pkg::fer_op_s op_in,
  input wire logic [fer_pkg::EX_N-1:0] trap_dis_in,
  output fer_pkg::fer_dec_s dec_out
);
  import fer_pkg::*;
  logic [EX_N-1:0] exc;
  logic [EX_N-1:0] en;

  always_comb begin
    exc = op_in.exc;
    exc[EX_D] = op_in.exc[EX_D] | op_in.denorm | op_in.unnorm;
    en = exc & ~trap_dis_in;
    dec_out = '0;
    if (|(en & FAULT_MASK)) begin
      // faults win: nothing is written back, no status flag moves
      dec_out.fault = 1'b1;
      dec_out.cause[EX_V] = en[EX_V];
      dec_out.cause[EX_Z] = en[EX_Z];
      dec_out.cause[EX_D] = en[EX_D];
    end else begin
      dec_out.wr_result = 1'b1;
      dec_out.flags = exc;
      if (|(en & TRAP_MASK)) begin
        dec_out.trap = 1'b1;
        dec_out.cause[EX_O] = en[EX_O];
        dec_out.cause[EX_U] = en[EX_U];
        dec_out.cause[EX_I] = exc[EX_I];
        dec_out.cause[C_FPA] = exc[EX_I] & op_in.fpa;
      end
    end
  end
endmodule : fer_decode
`default_nettype wire

/* File: design/fer_pkg.sv */
package fer_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ISR_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] FP_STATUS_REGISTER_OFS = 4'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // exception order in every six-bit vector
  localparam int EX_V = 0;
  localparam int EX_D = 1;
  localparam int EX_Z = 2;
  localparam int EX_O = 3;
  localparam int EX_U = 4;
  localparam int EX_I = 5;
  localparam int EX_N = 6;
  // cause field: six exception bits plus fraction_bumped_bit
  localparam int C_FPA = 6;
  localparam int CAUSE_W = 7;
  localparam logic [CAUSE_W-1:0] ISR_RST = 7'h00;
  // status register: trap disables in [5:0], then four status fields
  localparam int NSF = 4;
  localparam int SF_LSB = 6;
  localparam int FP_STATUS_REGISTER_W = SF_LSB + NSF * EX_N;
  localparam logic [FP_STATUS_REGISTER_W-1:0] FP_STATUS_REGISTER_RST = 30'h0000003F;
  localparam logic [EX_N-1:0] FAULT_MASK = 6'h07;
  localparam logic [EX_N-1:0] TRAP_MASK = 6'h38;
  localparam int EXP_W = 17;
  localparam int SIG_W = 64;

  typedef struct packed {
    logic unnorm;
    logic denorm;
    logic [EX_N-1:0] exc;
    logic fpa;
    logic [1:0] sf;
    logic sign;
    logic [EXP_W-1:0] exp;
    logic [SIG_W-1:0] sig;
  } fer_op_s;

  typedef struct packed {
    logic sign;
    logic [EXP_W-1:0] exp;
    logic [SIG_W-1:0] sig;
  } fer_res_s;

  typedef struct packed {
    logic fault;
    logic trap;
    logic [CAUSE_W-1:0] cause;
    logic [EX_N-1:0] flags;
    logic wr_result;
  } fer_dec_s;

  typedef enum logic [1:0] {FER_VEC_NONE, FER_VEC_FAULT, FER_VEC_TRAP} fer_vec_e;
endpackage : fer_pkg

/* File: design/fer_top.sv */
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module fer_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic s_axil_awvalid_in,
  output logic s_axil_awready_out,
  input wire logic [fer_pkg::ADDR_W-1:0] s_axil_awaddr_in,
  input wire logic s_axil_wvalid_in,
  output logic s_axil_wready_out,
  input wire logic [31:0] s_axil_wdata_in,
  input wire logic [3:0] s_axil_wstrb_in,
  output logic s_axil_bvalid_out,
  input wire logic s_axil_bready_in,
  output logic [1:0] s_axil_bresp_out,
  input wire logic s_axil_arvalid_in,
  output logic s_axil_arready_out,
  input wire logic [fer_pkg::ADDR_W-1:0] s_axil_araddr_in,
  output logic s_axil_rvalid_out,
  input wire logic s_axil_rready_in,
  output logic [31:0] s_axil_rdata_out,
  output logic [1:0] s_axil_rresp_out,
  input wire logic op_valid_in,
  input wire fer_pkg::fer_op_s op_in,
  output logic op_ready_out,
  output logic res_we_out,
  output fer_pkg::fer_res_s res_out,
  output logic fault_vec_out,
  output logic trap_vec_out
);
  import fer_pkg::*;

  logic [CAUSE_W-1:0] isr_r;
  logic [FP_STATUS_REGISTER_W-1:0] fp_status_register_r;
  fer_vec_e pend_r;
  fer_dec_s dec;
  logic take;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [31:0] wmask;
  logic [FP_STATUS_REGISTER_W-1:0] fp_status_register_sw;
  logic [FP_STATUS_REGISTER_W-1:0] fp_status_register_set;

  fer_decode fer_decode_inst (
    .op_in(op_in),
    .trap_dis_in(fp_status_register_r[EX_N-1:0]),
    .dec_out(dec)
  );

  fer_axil fer_axil_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .awvalid_in(s_axil_awvalid_in),
    .awready_out(s_axil_awready_out),
    .awaddr_in(s_axil_awaddr_in),
    .wvalid_in(s_axil_wvalid_in),
    .wready_out(s_axil_wready_out),
    .wdata_in(s_axil_wdata_in),
    .wstrb_in(s_axil_wstrb_in),
    .bvalid_out(s_axil_bvalid_out),
    .bready_in(s_axil_bready_in),
    .bresp_out(s_axil_bresp_out),
    .arvalid_in(s_axil_arvalid_in),
    .arready_out(s_axil_arready_out),
    .araddr_in(s_axil_araddr_in),
    .rvalid_out(s_axil_rvalid_out),
    .rready_in(s_axil_rready_in),
    .rdata_out(s_axil_rdata_out),
    .rresp_out(s_axil_rresp_out),
    .wr_en_out(wr_en),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  assign take = op_valid_in && op_ready_out;
  assign wr_ok = (wr_addr == ISR_OFS) || (wr_addr == FP_STATUS_REGISTER_OFS);
  assign rd_ok = (rd_addr == ISR_OFS) || (rd_addr == FP_STATUS_REGISTER_OFS);

  always_comb begin
    rd_data = '0;
    if (rd_addr == ISR_OFS) begin
      rd_data[CAUSE_W-1:0] = isr_r;
    end else if (rd_addr == FP_STATUS_REGISTER_OFS) begin
      rd_data[FP_STATUS_REGISTER_W-1:0] = fp_status_register_r;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wmask[gb*8 +: 8] = {8{wr_strb[gb]}};
    end
  endgenerate

  // software writes merge first, then hardware sets on top so no event is lost
  always_comb begin
    fp_status_register_sw = fp_status_register_r;
    if (wr_en && wr_addr == FP_STATUS_REGISTER_OFS) begin
      fp_status_register_sw = (fp_status_register_r & ~wmask[FP_STATUS_REGISTER_W-1:0]) | (wr_data[FP_STATUS_REGISTER_W-1:0] & wmask[FP_STATUS_REGISTER_W-1:0]);
    end
    fp_status_register_set = '0;
    if (take) begin
      fp_status_register_set[SF_LSB + op_in.sf * EX_N +: EX_N] = dec.flags;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fp_status_register_r <= FP_STATUS_REGISTER_RST;
    end else begin
      fp_status_register_r <= fp_status_register_sw | fp_status_register_set;
    end
  end

  // a new interruption replaces the whole cause field in one edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      isr_r <= ISR_RST;
    end else if (take && (dec.fault || dec.trap)) begin
      isr_r <= dec.cause;
    end else if (wr_en && wr_addr == ISR_OFS && wr_strb[0]) begin
      isr_r <= wr_data[CAUSE_W-1:0];
    end
  end

  // result passes with its unbounded exponent as is; scaling is software's job
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      res_we_out <= 1'b0;
      res_out <= '0;
    end else begin
      res_we_out <= take && dec.wr_result;
      if (take && dec.wr_result) begin
        res_out.sign <= op_in.sign;
        res_out.exp <= op_in.exp;
        res_out.sig <= op_in.sig;
      end
    end
  end

  // vector leaves one edge after the registers so handlers see settled state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend_r <= FER_VEC_NONE;
      op_ready_out <= 1'b0;
      fault_vec_out <= 1'b0;
      trap_vec_out <= 1'b0;
    end else begin
      fault_vec_out <= 1'b0;
      trap_vec_out <= 1'b0;
      case (pend_r)
        FER_VEC_NONE: begin
          op_ready_out <= 1'b1;
          if (take && dec.fault) begin
            pend_r <= FER_VEC_FAULT;
            op_ready_out <= 1'b0;
          end else if (take && dec.trap) begin
            pend_r <= FER_VEC_TRAP;
            op_ready_out <= 1'b0;
          end
        end
        FER_VEC_FAULT: begin
          fault_vec_out <= 1'b1;
          pend_r <= FER_VEC_NONE;
          op_ready_out <= 1'b1;
        end
        FER_VEC_TRAP: begin
          trap_vec_out <= 1'b1;
          pend_r <= FER_VEC_NONE;
          op_ready_out <= 1'b1;
        end
        default: begin
          pend_r <= FER_VEC_NONE;
        end
      endcase
    end
  end

  a_fault_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.fault |=> !res_we_out ##1 fault_vec_out)
    else $error("fault wrote a result or missed its vector");

  a_bad_op_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    take && op_in.exc[EX_V] && !fp_status_register_r[EX_V] |=> isr_r[EX_V] && !res_we_out)
    else $error("invalid operation fault did not set its cause");

  a_divz_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    take && op_in.exc[EX_Z] && !fp_status_register_r[EX_Z] |=> isr_r[EX_Z] ##1 fault_vec_out)
    else $error("divide by zero fault not reported");

  a_subnorm_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    take && op_in.unnorm && !fp_status_register_r[EX_D] |=> isr_r[EX_D])
    else $error("unnormal operand did not raise the denormal cause");

  a_ovf_trap: assert property (@(posedge clk_in) disable iff (rst_in)
    take && !dec.fault && op_in.exc[EX_O] && !fp_status_register_r[EX_O]
      |=> isr_r[EX_O] && res_we_out ##1 trap_vec_out)
    else $error("overflow trap not reported with its result");

  a_ovf_status: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.trap && op_in.exc[EX_O]
      |=> fp_status_register_r[SF_LSB + $past(op_in.sf) * EX_N + EX_O])
    else $error("overflow status flag not set");

  a_unf_status: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.trap && op_in.exc[EX_U]
      |=> fp_status_register_r[SF_LSB + $past(op_in.sf) * EX_N + EX_U] && isr_r[EX_U] == !$past(fp_status_register_r[EX_U]))
    else $error("underflow status or cause wrong");

  a_exp_kept: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.trap |=> res_out.exp == $past(op_in.exp))
    else $error("trapped exponent was altered");

  a_vec_after_regs: assert property (@(posedge clk_in) disable iff (rst_in)
    fault_vec_out || trap_vec_out |-> $past(!op_ready_out) && !$past(fault_vec_out || trap_vec_out))
    else $error("vector not preceded by register update");

  a_trap_inx_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.trap |=> isr_r[EX_I] == $past(op_in.exc[EX_I]))
    else $error("inexact cause bit wrong on trap");

  a_unf_trap: assert property (@(posedge clk_in) disable iff (rst_in)
    take && !dec.fault && op_in.exc[EX_U] && !fp_status_register_r[EX_U] |=> isr_r[EX_U] && res_we_out ##1 trap_vec_out)
    else $error("underflow trap not reported with its result");

  a_fpa_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.trap |=> isr_r[C_FPA] == ($past(op_in.fpa) && $past(op_in.exc[EX_I])))
    else $error("rounded-up cause bit wrong on trap");

  a_inx_status: assert property (@(posedge clk_in) disable iff (rst_in)
    take && !dec.fault && op_in.exc[EX_I] |=> fp_status_register_r[SF_LSB + $past(op_in.sf) * EX_N + EX_I])
    else $error("inexact status flag not set");

  a_fault_no_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.fault && !wr_en |=> $stable(fp_status_register_r))
    else $error("fault moved a status flag");

  a_denorm_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    take && op_in.denorm && !fp_status_register_r[EX_D] |=> isr_r[EX_D] ##1 fault_vec_out)
    else $error("denormal operand did not fault");

  a_disabled_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    take && (op_in.exc & ~fp_status_register_r[EX_N-1:0]) == '0 && !op_in.denorm && !op_in.unnorm
      |=> ##1 !fault_vec_out && !trap_vec_out)
    else $error("vector taken with every exception disabled");

  a_res_unchanged: assert property (@(posedge clk_in) disable iff (rst_in)
    res_we_out |-> res_out.sig == $past(op_in.sig) && res_out.sign == $past(op_in.sign))
    else $error("delivered result was altered");

  a_vec_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
    fault_vec_out || trap_vec_out |=> !fault_vec_out && !trap_vec_out)
    else $error("vector held longer than one cycle");

  a_vec_excl: assert property (@(posedge clk_in) disable iff (rst_in)
    !(fault_vec_out && trap_vec_out))
    else $error("fault and trap vector together");

  a_vec_ready: assert property (@(posedge clk_in) disable iff (rst_in)
    fault_vec_out || trap_vec_out |-> op_ready_out)
    else $error("port not reopened with the vector");

  a_fault_causes: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.fault |=> !isr_r[EX_O] && !isr_r[EX_U] && !isr_r[EX_I] && !isr_r[C_FPA])
    else $error("fault left trap cause bits set");

  a_trap_causes: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.trap |=> !isr_r[EX_V] && !isr_r[EX_Z] && !isr_r[EX_D])
    else $error("trap left fault cause bits set");

  a_trap_result: assert property (@(posedge clk_in) disable iff (rst_in)
    take && dec.trap |=> res_we_out)
    else $error("trap delivered no result");

  a_res_from_take: assert property (@(posedge clk_in) disable iff (rst_in)
    res_we_out |-> $past(take))
    else $error("result written without an operation");

  a_fault_vec_src: assert property (@(posedge clk_in) disable iff (rst_in)
    fault_vec_out |-> $past(pend_r == FER_VEC_FAULT))
    else $error("fault vector without a pending fault");

  a_trap_vec_src: assert property (@(posedge clk_in) disable iff (rst_in)
    trap_vec_out |-> $past(pend_r == FER_VEC_TRAP))
    else $error("trap vector without a pending trap");

  a_sticky_flags: assert property (@(posedge clk_in) disable iff (rst_in)
    !take && !wr_en |=> $stable(fp_status_register_r))
    else $error("status register moved with no cause");
endmodule : fer_top
`default_nettype wire

/* File: verif/fp_exception_reporting_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module fp_exception_reporting_tb;
  import fer_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, opv = 1'b0;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic [3:0] ws = 4'hF;
  fer_op_s opi = '0;
  logic awr, wr, bv, arr, rv, opr, we, fv, tv;
  logic [1:0] br, rr;
  logic [31:0] rd;
  fer_res_s res;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  fer_top fer_top_inst (.clk_in(clk_in), .rst_in(rst_in),
    .s_axil_awvalid_in(awv), .s_axil_awready_out(awr), .s_axil_awaddr_in(awa),
    .s_axil_wvalid_in(wv), .s_axil_wready_out(wr), .s_axil_wdata_in(wd),
    .s_axil_wstrb_in(ws), .s_axil_bvalid_out(bv), .s_axil_bready_in(brdy),
    .s_axil_bresp_out(br), .s_axil_arvalid_in(arv), .s_axil_arready_out(arr),
    .s_axil_araddr_in(ara), .s_axil_rvalid_out(rv), .s_axil_rready_in(rrdy),
    .s_axil_rdata_out(rd), .s_axil_rresp_out(rr), .op_valid_in(opv), .op_in(opi),
    .op_ready_out(opr), .res_we_out(we), .res_out(res), .fault_vec_out(fv),
    .trap_vec_out(tv));

  initial begin
    forever #25 clk_in = ~clk_in;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ceiling well above the roughly 130 cycles the tests need
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [81:0] seen, input logic [81:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // address and data offered together, each dropped once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, dd, ta, tw;
    logic [1:0] b;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk_in);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    while (!(ad && dd)) begin
      @(negedge clk_in);
      ta = !ad && awr === 1'b1;
      tw = !dd && wr === 1'b1;
      @(posedge clk_in);
      if (ta) begin
        awv <= 1'b0;
        ad = 1'b1;
      end
      if (tw) begin
        wv <= 1'b0;
        dd = 1'b1;
      end
    end
    brdy <= 1'b1;
    do @(negedge clk_in); while (bv !== 1'b1);
    b = br;
    @(posedge clk_in);
    brdy <= 1'b0;
    check(b, er);
  endtask : axw

  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_in);
    arv <= 1'b1;
    ara <= a;
    do @(negedge clk_in); while (arr !== 1'b1);
    @(posedge clk_in);
    arv <= 1'b0;
    rrdy <= 1'b1;
    do @(negedge clk_in); while (rv !== 1'b1);
    d = rd;
    r = rr;
    @(posedge clk_in);
    rrdy <= 1'b0;
    check(r, er);
    check(d, ed);
  endtask : axr

  function automatic fer_op_s mk(input logic [5:0] e, input logic dn, un, fp,
                                 input logic [1:0] s);
    mk = '0;
    mk.exc = e;
    mk.denorm = dn;
    mk.unnorm = un;
    mk.fpa = fp;
    mk.sf = s;
    mk.sign = 1'b1;
    mk.exp = 17'h1FFFF;
    mk.sig = 64'hC000000000000001;
  endfunction : mk

  // watch four cycles after the take: result, then the vector
  task automatic op_run(input fer_op_s o, input logic ef, input logic et);
    logic sw, sf, st;
    fer_res_s r;
    sw = 1'b0;
    sf = 1'b0;
    st = 1'b0;
    r = '0;
    @(posedge clk_in);
    opv <= 1'b1;
    opi <= o;
    do @(negedge clk_in); while (opr !== 1'b1);
    @(posedge clk_in);
    opv <= 1'b0;
    for (int n = 0; n < 4; n++) begin
      @(negedge clk_in);
      if (we === 1'b1) begin
        sw = 1'b1;
        r = res;
      end
      if (fv === 1'b1) sf = 1'b1;
      if (tv === 1'b1) st = 1'b1;
    end
    check(sf, ef);
    check(st, et);
    check(sw, !ef);
    if (!ef) check(r, {o.sign, o.exp, o.sig});
  endtask : op_run

  task automatic test_reset;
    axr(4'h0, 32'h0, RESP_OKAY);
    axr(4'h4, 32'h3F, RESP_OKAY);
    axr(4'h8, 32'h0, RESP_SLVERR);
    axw(4'h8, 32'hFFFFFFFF, RESP_SLVERR);
    $display("test reset done");
  endtask : test_reset

  // disabled overflow: no vector, flags still sticky, cause untouched
  task automatic test_disabled;
    op_run(mk(6'h28, 1'b0, 1'b0, 1'b1, 2'h0), 1'b0, 1'b0);
    axr(4'h4, 32'hA3F, RESP_OKAY);
    axr(4'h0, 32'h0, RESP_OKAY);
    $display("test disabled done");
  endtask : test_disabled

  task automatic test_faults;
    logic [5:0] e;
    axw(4'h4, 32'h0, RESP_OKAY);
    axr(4'h4, 32'h0, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      e = (i < 3) ? (6'h01 << i) : 6'h00;
      op_run(mk(e, i == 3, i == 4, 1'b0, 2'h1), 1'b1, 1'b0);
      axr(4'h0, (i < 3) ? (32'h1 << i) : 32'h2, RESP_OKAY);
      axr(4'h4, 32'h0, RESP_OKAY);
    end
    $display("test faults done");
  endtask : test_faults

  // overflow, underflow, inexact traps, each into a different field
  task automatic test_traps;
    logic [5:0] e;
    logic [31:0] interruption_status_register, fp_status_register;
    logic fp;
    fp_status_register = 32'h0;
    for (int i = 0; i < 3; i++) begin
      e = (i == 0) ? 6'h28 : (i == 1) ? 6'h30 : 6'h20;
      fp = (i != 1);
      interruption_status_register = {25'h0, fp, e[5:0]} & 32'h7F;
      interruption_status_register = (i == 1) ? 32'h30 : interruption_status_register;
      fp_status_register = fp_status_register | (32'(e) << (6 + 6 * (i + 1)));
      op_run(mk(e, 1'b0, 1'b0, fp, 2'(i + 1)), 1'b0, 1'b1);
      axr(4'h0, interruption_status_register, RESP_OKAY);
      axr(4'h4, fp_status_register, RESP_OKAY);
    end
    $display("test traps done");
  endtask : test_traps

  // handler side: the delivered exponent is raw, software applies the adjustment
  task automatic test_handler;
    op_run(mk(6'h08, 1'b0, 1'b0, 1'b0, 2'h0), 1'b0, 1'b1);
    check(17'(res.exp - 17'h18000), 17'h07FFF);
    check(17'(res.exp + 17'h18000), 17'h17FFF);
    check(32'h3 << (8 - 2), 32'hC0);
    check(32'h3 << (11 - 2), 32'h600);
    check(32'h3 << (15 - 2), 32'h6000);
    $display("test handler done");
  endtask : test_handler

  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    test_reset();
    test_disabled();
    test_faults();
    test_traps();
    test_handler();
    end_of_test();
  end
endmodule : fp_exception_reporting_tb
`default_nettype wire
